// ### hdl/ccu_pkg.sv
// package: register map, field positions, modes, state types of the capture/compare unit
package ccu_pkg;
   // =====================================================
   // register indices on the plain register port
   localparam logic [2:0] ADDR_CTRL = 3'h0;  // capture_compare_control
   localparam logic [2:0] ADDR_PAIR_LO = 3'h1;  // capture_compare_low_byte
   localparam logic [2:0] ADDR_PAIR_HI = 3'h2;  // capture_compare_high_byte
   localparam logic [2:0] ADDR_T2_LO = 3'h3;  // second_timer_low_byte
   localparam logic [2:0] ADDR_T2_HI = 3'h4;  // second_timer_high_byte
   localparam logic [2:0] ADDR_T2_CTL = 3'h5;  // second_timer_control
   localparam logic [2:0] ADDR_STATUS = 3'h6;  // flags and interrupt enable
   localparam logic [2:0] ADDR_IO = 3'h7;  // pin and timestamp control
   // =====================================================
   // field positions
   localparam int CTL_DUTY_LSB = 4;  // duty_low_bits at [5:4]
   localparam int T2C_RD16 = 7;  // 16-bit read/write mode
   localparam int T2C_SEL_HI = 6;  // time_base_select_high
   localparam int T2C_PS_LSB = 4;  // input prescale at [5:4]
   localparam int T2C_SEL_LO = 3;  // time_base_select_low
   localparam int T2C_EXT = 1;  // external clock source
   localparam int T2C_ON = 0;  // timer on
   localparam int ST_FLAG = 0;  // unit_interrupt_flag, write one to clear
   localparam int ST_OVF = 1;  // second_timer_overflow_flag, write one to clear
   localparam int ST_IE = 2;  // unit_interrupt_enable
   localparam int IO_CANTS = 0;  // can_timestamp_enable
   localparam int IO_DIR = 1;  // pin drives out when set
   localparam int IO_PORT = 2;  // port data latch
   // =====================================================
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] T2_CTL_RST = 8'h00;
   localparam logic [15:0] CNT_WRAP = 16'hFFFF;  // last count before overflow
   // =====================================================
   // unit_mode_field encodings
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_RSVD = 4'h1;  // no function
   localparam logic [3:0] MODE_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_CAN = 4'h3;
   localparam logic [3:0] MODE_FALL = 4'h4;
   localparam logic [3:0] MODE_RISE = 4'h5;
   localparam logic [3:0] MODE_RISE4 = 4'h6;
   localparam logic [3:0] MODE_RISE16 = 4'h7;
   localparam logic [3:0] MODE_SET_HI = 4'h8;
   localparam logic [3:0] MODE_SET_LO = 4'h9;
   localparam logic [3:0] MODE_SWINT = 4'hA;
   localparam logic [3:0] MODE_SPECIAL = 4'hB;
   localparam logic [1:0] MODE_PWM_TOP = 2'h3;  // upper two bits of 11xx
   // =====================================================
   // capture prescaler terminal counts
   localparam logic [3:0] PRE4_LAST = 4'h3;
   localparam logic [3:0] PRE16_LAST = 4'hF;
   // =====================================================
   // carriers and state
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ccu_bus_req_s;
   typedef struct packed {
      logic [15:0] cnt;  // second_16bit_timer
      logic [7:0] hibuf;  // high byte buffer for 16-bit access
      logic [2:0] psc;  // input prescaler
      logic ext_prev;  // last external clock level
   } ccu_tmr_s;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] pair_lo;
      logic [7:0] pair_hi;
      logic [7:0] t2_ctl;
      logic flag;
      logic ovf_flag;
      logic ie;
      logic can_ts;
      logic pin_dir;
      logic port_bit;
      logic cmp_latch;  // compare output latch
      logic src_prev;  // last capture source level
      logic can_prev;
      logic match_prev;
      logic [3:0] pre_cnt;
      logic [3:0] mode_prev;
      logic ft_clear;
      logic adc_start;
      logic [9:0] duty;
      logic pin_out;
      logic [7:0] rdata;
   } ccu_state_s;
endpackage

// ### hdl/ccu_sync.sv
// two-stage synchroniser for the capture pin and the external timer clock
module ccu_sync
   import ccu_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [1:0] async_in,
   output logic [1:0] sync_out
);
   // =====================================================
   // state: first and second stage
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
   } ccu_sync_s;
   ccu_sync_s s_reg;
   ccu_sync_s s_next;

   // first stage feeds only the second stage
   always_comb begin
      s_next = s_reg;
      s_next.s1 = async_in;
      s_next.s2 = s_reg.s1;
   end

   // register the stages
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sync_out = s_reg.s2;
endmodule

// ### hdl/ccu_timer.sv
// second 16-bit timer with prescaler, 16-bit access buffer and special-event clear
module ccu_timer
   import ccu_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] ctl,
   input wire logic ext_lvl,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic rd_lo,
   input wire logic [7:0] wdata,
   input wire logic clear,
   output logic [15:0] count,
   output logic [7:0] hi_view,
   output logic ovf
);
   ccu_tmr_s t_reg;  // timer state
   ccu_tmr_s t_next;
   logic tick;  // input clock edge
   logic [2:0] ps_mask;  // prescale terminal
   logic inc;  // count advances this cycle
   logic wr_any;

   // count, writes and clear; a write beats the clear
   always_comb begin
      t_next = t_reg;
      t_next.ext_prev = ext_lvl;
      ps_mask = 3'((4'h1 << ctl[T2C_PS_LSB +: 2]) - 4'h1);
      tick = ctl[T2C_ON] && (!ctl[T2C_EXT] || (ext_lvl && !t_reg.ext_prev));
      inc = tick && (t_reg.psc == ps_mask);
      wr_any = wr_lo || wr_hi;
      if (tick) begin
         t_next.psc = inc ? 3'h0 : t_reg.psc + 3'h1;
      end
      if (inc) begin
         t_next.cnt = t_reg.cnt + 16'h0001;
      end
      // the clear never passes through the overflow path
      if (clear) begin  // R1
         t_next.cnt = 16'h0000;
      end
      // a write in the same cycle wins over the clear
      if (ctl[T2C_RD16]) begin
         if (wr_hi) begin
            t_next.hibuf = wdata;
            t_next.cnt = t_reg.cnt;  // R3
         end
         if (wr_lo) begin
            t_next.cnt = {t_reg.hibuf, wdata};  // R3
         end
         if (rd_lo) begin
            t_next.hibuf = t_reg.cnt[15:8];
         end
      end else begin
         if (wr_lo) begin
            t_next.cnt = {t_reg.cnt[15:8], wdata};  // R3
         end
         if (wr_hi) begin
            t_next.cnt = {wdata, t_reg.cnt[7:0]};  // R3
         end
      end
      // overflow only on a true wrap of the count
      ovf = inc && (t_reg.cnt == CNT_WRAP) && !clear && !wr_any;  // R2
   end

   // register the state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end

   assign count = t_reg.cnt;
   assign hi_view = ctl[T2C_RD16] ? t_reg.hibuf : t_reg.cnt[15:8];
endmodule

// ### hdl/ccu_top.sv
// capture/compare unit: modes, capture, compare, special event, register port
//
// Functional notes
// R1 - special-event match clears second timer when selected
// R2 - that clear never sets overflow flag
// R3 - timer write wins over special-event clear
// R4 - pair acts as period in special mode
// R5 - mode 0000 off and reset; 0001 reserved
// R6 - 0010 toggles pin on match, sets flag
// R7 - 0011 captures on CAN message received
// R8 - 0100..0111 fall, rise, 4th, 16th rise
// R9 - 1000/1001 preset pin, force on match
// R10 - 1010 pin untouched, flag set on match
// R11 - special match: flag, timer clear, A/D start
// R12 - 11xx PWM; duty is low byte plus bits
// R13 - capture copies selected timer into pair
// R14 - capture sets sticky flag, software clears
// R15 - new capture overwrites pair, no overrun
// R16 - driven pin level change counts as edge
// R17 - software keeps timers synchronous
// R18 - timer choice from second timer control
// R19 - prescaler cleared when off or not capture
// R20 - prescaler switch keeps count, may flag
// R21 - software masks interrupt during mode change
// R22 - timestamp enable makes CAN pulse the source
// R23 - select 1x second timer, else first
// R24 - pin synchronised through two flip-flops
module ccu_top
   import ccu_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire ccu_bus_req_s bus,
   output logic [7:0] rdata,
   input wire logic [15:0] first_timer_count,
   input wire logic can_rx_pulse,
   input wire logic adc_enable,
   input wire logic pwm_level,
   input wire logic pin_in,
   input wire logic timer_ext_clk,
   output logic pin_out,
   output logic pin_oe,
   output logic first_timer_clear,
   output logic adc_start,
   output logic unit_flag,
   output logic unit_ie,
   output logic timer_ovf_flag,
   output logic [9:0] duty_value
);
   // =====================================================
   // mode decoding
   function automatic logic f_is_capture(input logic [3:0] m);
      f_is_capture = (m >= MODE_CAN) && (m <= MODE_RISE16);
   endfunction

   function automatic logic f_is_compare(input logic [3:0] m);
      f_is_compare = (m == MODE_TOGGLE) || ((m >= MODE_SET_HI) && (m <= MODE_SPECIAL));
   endfunction

   // =====================================================
   // signals
   ccu_state_s s_reg;  // state of the unit outside the second timer and the synchroniser
   ccu_state_s s_next;
   logic [1:0] sync_lvl;  // synchronised pin and external clock
   logic [15:0] t2_count;  // second timer count
   logic [7:0] t2_hi_view;  // high byte as software reads it
   logic t2_ovf;  // second timer wrap pulse
   logic t2_clear;  // special-event clear of the second timer
   logic t2_wr_lo;
   logic t2_wr_hi;
   logic t2_rd_lo;
   logic [3:0] mode;  // unit_mode_field
   logic sel_second;  // this unit runs on the second timer
   logic [15:0] sel_cnt;  // count of the selected time-base
   logic src_lvl;  // capture source level
   logic edge_rise;
   logic edge_fall;
   logic can_rise;
   logic use_can;
   logic cap_evt;  // capture taken this cycle
   logic match;
   logic match_evt;  // first cycle of a compare match
   logic flag_clr;  // software clear of the unit flag
   logic ovf_clr;
   logic [3:0] pre_last;  // prescaler terminal count

   // =====================================================
   // synchroniser for the asynchronous inputs
   ccu_sync u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in({timer_ext_clk, pin_in}),
      .sync_out(sync_lvl)  // R24
   );

   // =====================================================
   // second timer
   ccu_timer u_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .ctl(s_reg.t2_ctl),
      .ext_lvl(sync_lvl[1]),
      .wr_lo(t2_wr_lo),
      .wr_hi(t2_wr_hi),
      .rd_lo(t2_rd_lo),
      .wdata(bus.wdata),
      .clear(t2_clear),
      .count(t2_count),
      .hi_view(t2_hi_view),
      .ovf(t2_ovf)
   );

   // =====================================================
   // next-state logic
   always_comb begin
      s_next = s_reg;
      mode = s_reg.ctrl[3:0];
      t2_wr_lo = bus.wr && (bus.addr == ADDR_T2_LO);
      t2_wr_hi = bus.wr && (bus.addr == ADDR_T2_HI);
      t2_rd_lo = bus.rd && (bus.addr == ADDR_T2_LO);
      // time-base: only the high select bit picks the second timer here
      sel_second = s_reg.t2_ctl[T2C_SEL_HI];  // R18 R23
      sel_cnt = sel_second ? t2_count : first_timer_count;  // R23
      // a driven pin feeds its own level back as the capture source
      src_lvl = s_reg.pin_dir ? s_reg.pin_out : sync_lvl[0];  // R16
      can_rise = can_rx_pulse && !s_reg.can_prev;
      use_can = s_reg.can_ts || (mode == MODE_CAN);  // R22
      edge_rise = use_can ? can_rise : (src_lvl && !s_reg.src_prev);  // R22
      edge_fall = use_can ? can_rise : (!src_lvl && s_reg.src_prev);
      s_next.src_prev = src_lvl;
      s_next.can_prev = can_rx_pulse;
      pre_last = (mode == MODE_RISE4) ? PRE4_LAST : PRE16_LAST;
      // capture event selection
      unique case (mode)
         MODE_CAN: cap_evt = can_rise;  // R7
         MODE_FALL: cap_evt = edge_fall;  // R8
         MODE_RISE: cap_evt = edge_rise;  // R8
         MODE_RISE4, MODE_RISE16: cap_evt = edge_rise && (s_reg.pre_cnt == pre_last);  // R8
         default: cap_evt = 1'b0;
      endcase
      // prescaler: kept across capture modes, cleared elsewhere
      if (!f_is_capture(mode)) begin
         s_next.pre_cnt = 4'h0;  // R19
      end else if (edge_rise && ((mode == MODE_RISE4) || (mode == MODE_RISE16))) begin
         s_next.pre_cnt = (s_reg.pre_cnt == pre_last) ? 4'h0 : s_reg.pre_cnt + 4'h1;  // R20
      end
      // compare: the pair is the period in special mode
      match = f_is_compare(mode) && (sel_cnt == {s_reg.pair_hi, s_reg.pair_lo});  // R4
      match_evt = match && !s_reg.match_prev;
      s_next.match_prev = match;
      // software register writes
      if (bus.wr) begin
         unique case (bus.addr)
            ADDR_CTRL: s_next.ctrl = {2'b00, bus.wdata[5:0]};
            ADDR_PAIR_LO: s_next.pair_lo = bus.wdata;
            ADDR_PAIR_HI: s_next.pair_hi = bus.wdata;
            ADDR_T2_CTL: s_next.t2_ctl = bus.wdata;
            ADDR_STATUS: s_next.ie = bus.wdata[ST_IE];
            ADDR_IO: begin
               s_next.can_ts = bus.wdata[IO_CANTS];
               s_next.pin_dir = bus.wdata[IO_DIR];
               s_next.port_bit = bus.wdata[IO_PORT];
            end
            default: ;
         endcase
      end
      flag_clr = bus.wr && (bus.addr == ADDR_STATUS) && bus.wdata[ST_FLAG];
      ovf_clr = bus.wr && (bus.addr == ADDR_STATUS) && bus.wdata[ST_OVF];
      // capture overwrites the pair, even over a software write
      if (cap_evt) begin
         s_next.pair_lo = sel_cnt[7:0];  // R13 R15
         s_next.pair_hi = sel_cnt[15:8];  // R13 R15
      end
      // compare latch: preset on mode entry, act on match
      s_next.mode_prev = mode;
      if (mode != s_reg.mode_prev) begin
         if (mode == MODE_SET_HI) begin
            s_next.cmp_latch = 1'b0;  // R9
         end else if (mode == MODE_SET_LO) begin
            s_next.cmp_latch = 1'b1;  // R9
         end
      end
      s_next.ft_clear = 1'b0;
      s_next.adc_start = 1'b0;
      t2_clear = 1'b0;
      if (match_evt) begin
         unique case (mode)
            MODE_TOGGLE: s_next.cmp_latch = !s_reg.cmp_latch;  // R6
            MODE_SET_HI: s_next.cmp_latch = 1'b1;  // R9
            MODE_SET_LO: s_next.cmp_latch = 1'b0;  // R9
            MODE_SPECIAL: begin
               t2_clear = sel_second;  // R1 R11
               s_next.ft_clear = !sel_second;  // R11
               s_next.adc_start = adc_enable;  // R11
            end
            default: ;  // software-only compare leaves the pin alone
         endcase
      end
      // off resets internal state; reserved code does nothing
      if (mode == MODE_OFF) begin
         s_next.cmp_latch = 1'b0;  // R5
         s_next.duty = 10'h000;  // R5
      end
      // sticky flags: a set beats a clear in the same cycle
      s_next.flag = (s_reg.flag && !flag_clr) || cap_evt || match_evt;  // R14 R6 R10
      s_next.ovf_flag = (s_reg.ovf_flag && !ovf_clr) || t2_ovf;  // R2
      // duty value only follows the registers in PWM mode
      if (mode[3:2] == MODE_PWM_TOP) begin
         s_next.duty = {s_next.pair_lo, s_next.ctrl[CTL_DUTY_LSB +: 2]};  // R12
      end
      // pin level by mode
      if (f_is_compare(s_next.ctrl[3:0]) || (s_next.ctrl[3:0] == MODE_OFF)) begin
         s_next.pin_out = s_next.cmp_latch;
      end else if (s_next.ctrl[3:2] == MODE_PWM_TOP) begin
         s_next.pin_out = pwm_level;
      end else begin
         s_next.pin_out = s_next.port_bit;
      end
      // read data one cycle after the strobe
      s_next.rdata = 8'h00;
      if (bus.rd) begin
         unique case (bus.addr)
            ADDR_CTRL: s_next.rdata = s_reg.ctrl;
            ADDR_PAIR_LO: s_next.rdata = s_reg.pair_lo;
            ADDR_PAIR_HI: s_next.rdata = s_reg.pair_hi;
            ADDR_T2_LO: s_next.rdata = t2_count[7:0];
            ADDR_T2_HI: s_next.rdata = t2_hi_view;
            ADDR_T2_CTL: s_next.rdata = s_reg.t2_ctl;
            ADDR_STATUS: s_next.rdata = {5'h00, s_reg.ie, s_reg.ovf_flag, s_reg.flag};
            ADDR_IO: s_next.rdata = {5'h00, s_reg.port_bit, s_reg.pin_dir, s_reg.can_ts};
            default: ;
         endcase
      end
   end

   // =====================================================
   // state register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // =====================================================
   // outputs, straight from state
   assign rdata = s_reg.rdata;
   assign pin_out = s_reg.pin_out;
   assign pin_oe = s_reg.pin_dir;
   assign first_timer_clear = s_reg.ft_clear;
   assign adc_start = s_reg.adc_start;
   assign unit_flag = s_reg.flag;
   assign unit_ie = s_reg.ie;
   assign timer_ovf_flag = s_reg.ovf_flag;
   assign duty_value = s_reg.duty;

   // =====================================================
   // assertions
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   special_clear_a: assert property ( // R1
      (t2_clear && !t2_wr_lo && !t2_wr_hi) |=> (t2_count == 16'h0000))
      else $error("special event did not clear second timer");
   clear_no_ovf_a: assert property ( // R2
      t2_clear |-> !t2_ovf)
      else $error("special event clear raised overflow");
   write_wins_a: assert property ( // R3
      (t2_clear && t2_wr_lo && !s_reg.t2_ctl[T2C_RD16] && !t2_wr_hi)
      |=> (t2_count[7:0] == $past(bus.wdata)))
      else $error("timer write lost to special event");
   off_resets_a: assert property ( // R5
      (mode == MODE_OFF) |=> (s_reg.pre_cnt == 4'h0) && !s_reg.cmp_latch)
      else $error("off mode kept state");
   toggle_match_a: assert property ( // R6
      (mode == MODE_TOGGLE && match_evt && s_next.ctrl[3:0] == MODE_TOGGLE)
      |=> (s_reg.cmp_latch != $past(s_reg.cmp_latch)) && s_reg.flag && (pin_out == s_reg.cmp_latch))
      else $error("toggle mode did not toggle");
   capture_copy_a: assert property ( // R13
      cap_evt |=> ({s_reg.pair_hi, s_reg.pair_lo} == $past(sel_cnt)) && s_reg.flag)
      else $error("capture did not copy count");
   flag_sticky_a: assert property ( // R14
      (s_reg.flag && !flag_clr) |=> s_reg.flag)
      else $error("flag cleared by hardware");
   force_high_a: assert property ( // R9
      (mode == MODE_SET_HI && match_evt) |=> s_reg.cmp_latch && s_reg.flag)
      else $error("force-high compare failed");
   prescale_four_a: assert property ( // R8
      (mode == MODE_RISE4 && s_reg.pre_cnt != PRE4_LAST) |-> !cap_evt)
      else $error("early capture in divide-by-four");
   swint_pin_a: assert property ( // R10
      (mode == MODE_SWINT && match_evt && s_next.ctrl[3:0] == MODE_SWINT)
      |=> (s_reg.cmp_latch == $past(s_reg.cmp_latch)) && s_reg.flag)
      else $error("software compare moved the pin");

   capture_seen_c: cover property (cap_evt ##1 s_reg.flag);
   special_seen_c: cover property (mode == MODE_SPECIAL && match_evt ##1 t2_count == 16'h0000);
   toggle_seen_c: cover property (mode == MODE_TOGGLE && match_evt);
   can_seen_c: cover property (mode == MODE_CAN && can_rise);
endmodule

// ### verification/ccu_far_model.sv
// far-side model: capture pin wire, first 16-bit timer and CAN receive pulse
module ccu_far_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic drive_lvl,
   input wire logic can_lvl,
   input wire logic first_timer_clear,
   input wire logic run,
   input wire logic ld,
   input wire logic [15:0] ld_val,
   output logic pin_in,
   output logic can_rx_pulse,
   output logic [15:0] first_timer_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================
   // pin wire: the unit's drive wins over the outside level
   assign pin_in = pin_oe ? pin_out : drive_lvl;
   // one rising pulse for each stored message
   assign can_rx_pulse = can_lvl;
   // =====================================================
   // first timer: load, special-event clear, count on the unit clock only
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         first_timer_count <= 16'h0000;
      end else if (ld) begin
         first_timer_count <= ld_val;
      end else if (first_timer_clear) begin
         first_timer_count <= 16'h0000;
      end else if (run) begin
         first_timer_count <= first_timer_count + 16'h0001;
      end
   end
endmodule

// ### verification/tb.sv
// testbench: register tasks, capture, compare and duty scenarios against reference values
module tb
   import ccu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================
   // stimulus, outputs and bookkeeping
   logic mclk = 0, rst_n = 0, can_lvl = 0, drive_lvl = 0, run = 0, ld = 0;
   logic [15:0] ld_val = 16'h0000;
   ccu_bus_req_s bus = '0;
   logic [7:0] rdata, d0, d1;
   logic [15:0] ftc, v, p, ep;
   logic pin_in, pin_out, pin_oe, ftclr, adc_st, flag, ie, ovf, can_p, ef;
   logic s_adc, s_clr, adc_en = 1'b1;
   logic [9:0] duty;
   int fails = 0, num_checks = 0, i, k, t, n;
   logic [3:0] cm [6] = '{MODE_FALL, MODE_RISE, MODE_RISE4, MODE_RISE16, MODE_CAN, MODE_RISE};
   int cd [6] = '{1, 1, 4, 16, 1, 1};  // events per capture
   logic [3:0] mm [5] = '{MODE_TOGGLE, MODE_SET_HI, MODE_SET_LO, MODE_SWINT, MODE_SPECIAL};
   logic [3:0] pre = 4'h4;  // pin before the match, one bit per mode
   logic [3:0] post = 4'h3;  // pin after the match
   ccu_far_model far (.mclk(mclk), .rst_n(rst_n), .pin_out(pin_out), .pin_oe(pin_oe),
      .drive_lvl(drive_lvl), .can_lvl(can_lvl), .first_timer_clear(ftclr), .run(run),
      .ld(ld), .ld_val(ld_val), .pin_in(pin_in), .can_rx_pulse(can_p),
      .first_timer_count(ftc));
   ccu_top DUT (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .first_timer_count(ftc), .can_rx_pulse(can_p), .adc_enable(adc_en), .pwm_level(1'b0),
      .pin_in(pin_in), .timer_ext_clk(1'b0), .pin_out(pin_out), .pin_oe(pin_oe),
      .first_timer_clear(ftclr), .adc_start(adc_st), .unit_flag(flag), .unit_ie(ie),
      .timer_ovf_flag(ovf), .duty_value(duty));
   // =====================================================
   // clock and pulse monitor
   initial forever #2 mclk = ~mclk;
   // pulses are remembered while run is high, forgotten while it is low
   always @(posedge mclk) begin
      s_adc <= run && (s_adc || adc_st === 1'b1);
      s_clr <= run && (s_clr || ftclr === 1'b1);
   end
   // =====================================================
   // shared tasks
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t ns: got %h expected %h", $time, seen, exp);
      end
   endtask
   task chk1(input logic seen, input logic exp);
      chk({15'h0000, seen}, {15'h0000, exp});
   endtask
   task cyc(input int c);
      repeat (c) @(posedge mclk);
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk) bus <= {a, d, 2'b10};
      @(posedge mclk) bus.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk) bus <= {a, 8'h00, 2'b01};
      @(posedge mclk) bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   // two writes back to back, strobe held high between them
   task wr2(input logic [2:0] a, b, input logic [7:0] d, e);
      @(posedge mclk) bus <= {a, d, 2'b10};
      @(posedge mclk) bus <= {b, e, 2'b10};
      @(posedge mclk) bus.wr <= 1'b0;
   endtask
   task load(input logic [15:0] x);
      @(posedge mclk) ld <= 1'b1;
      ld_val <= x;
      @(posedge mclk) ld <= 1'b0;
   endtask
   // one high pulse on the pin or the CAN line
   task pulse(input logic c);
      cyc(1);
      if (c) can_lvl <= 1'b1;
      else drive_lvl <= 1'b1;
      cyc(6);
      can_lvl <= 1'b0;
      drive_lvl <= 1'b0;
      cyc(6);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // bounded wait for the unit flag; a timeout ends the run
   task wait_flag;
      for (t = 0; t < 1000 && flag !== 1'b1; t++) cyc(1);
      if (t == 1000) begin
         fails++;
         give_verdict();
      end
   endtask
   // =====================================================
   // main sequence
   initial begin
      void'($urandom(20741));
      cyc(10);
      rst_n <= 1'b1;
      rd(ADDR_CTRL, d0);
      chk({8'h00, d0}, {8'h00, CTRL_RST});
      rd(ADDR_T2_CTL, d0);
      chk({8'h00, d0}, {8'h00, T2_CTL_RST});
      // capture modes, each entered from off
      for (i = 0; i < 6; i++) begin
         wr(ADDR_CTRL, CTRL_RST);
         wr(ADDR_T2_CTL, (i == 5) ? 8'h40 : 8'h00);
         wr(ADDR_IO, (i == 5) ? 8'h01 : 8'h00);
         wr(ADDR_CTRL, {4'h0, cm[i]});
         wr(ADDR_STATUS, 8'h01);
         ef = 0;
         n = (cd[i] == 1) ? 2 : cd[i];
         for (k = 1; k <= n; k++) begin
            v = 16'($urandom);
            if (i == 5) begin
               wr(ADDR_T2_HI, v[15:8]);
               wr(ADDR_T2_LO, v[7:0]);
            end else load(v);
            pulse(i >= 4);
            if (k % cd[i] == 0) begin
               ef = 1;
               ep = v;
            end
            chk1(flag, ef);
         end
         rd(ADDR_PAIR_LO, d0);
         rd(ADDR_PAIR_HI, d1);
         chk({d1, d0}, ep);
         $display("capture test %0d done", i);
      end
      wr(ADDR_CTRL, CTRL_RST);
      chk1(flag, 1'b1);
      // driven pin: a port write that changes the level is an edge
      wr(ADDR_T2_CTL, 8'h00);
      wr(ADDR_IO, 8'h02);
      wr(ADDR_CTRL, {4'h0, MODE_RISE});
      wr(ADDR_STATUS, 8'h01);
      #1 chk1(flag, 1'b0);
      v = 16'($urandom);
      load(v);
      wr(ADDR_IO, 8'h06);
      cyc(6);
      chk1(flag, 1'b1);
      rd(ADDR_PAIR_LO, d0);
      rd(ADDR_PAIR_HI, d1);
      chk({d1, d0}, v);
      // compare modes against the running first timer
      for (i = 0; i < 5; i++) begin
         wr(ADDR_CTRL, CTRL_RST);
         wr(ADDR_IO, 8'h02);
         wr(ADDR_STATUS, 8'h01);
         p = 16'h0064 + (16'($urandom) & 16'h00ff);
         wr(ADDR_PAIR_LO, p[7:0]);
         wr(ADDR_PAIR_HI, p[15:8]);
         load(16'h0000);
         run <= 1'b1;
         wr(ADDR_CTRL, {4'h0, mm[i]});
         cyc(1);
         #1 if (i < 4) chk1(pin_out, pre[i]);
         wait_flag();
         cyc(3);
         if (i < 4) chk1(pin_out, post[i]);
         if (i == 4) begin
            chk1(s_adc, 1'b1);
            chk1(s_clr, 1'b1);
            chk1(ftc < p, 1'b1);
            chk1(ovf, 1'b0);
         end
         run <= 1'b0;
         $display("compare test %0d done", i);
      end
      // special event on the second timer, converter off
      wr(ADDR_T2_HI, 8'h00);
      wr(ADDR_T2_LO, 8'h00);
      wr(ADDR_T2_CTL, 8'h41);
      wr(ADDR_STATUS, 8'h03);
      adc_en <= 1'b0;
      run <= 1'b1;
      wr(ADDR_CTRL, {4'h0, MODE_SPECIAL});
      wait_flag();
      cyc(2);
      rd(ADDR_T2_LO, d0);
      rd(ADDR_T2_HI, d1);
      chk1({d1, d0} < p, 1'b1);
      chk1(s_adc, 1'b0);
      chk1(s_clr, 1'b0);
      chk1(ovf, 1'b0);
      // timer write in the clear cycle
      wr(ADDR_T2_CTL, 8'h40);
      wr(ADDR_T2_LO, 8'h00);
      wr(ADDR_PAIR_LO, 8'h01);
      wr(ADDR_PAIR_HI, 8'h00);
      wr2(ADDR_PAIR_LO, ADDR_T2_LO, 8'h00, 8'h5A);
      rd(ADDR_T2_LO, d0);
      chk({8'h00, d0}, 16'h005A);
      wr(ADDR_T2_CTL, 8'h00);
      $display("timer test done");
      // reserved mode does nothing on a match
      wr(ADDR_CTRL, CTRL_RST);
      wr(ADDR_STATUS, 8'h01);
      wr(ADDR_CTRL, {4'h0, MODE_RSVD});
      load(16'h0000);
      run <= 1'b1;
      cyc(400);
      run <= 1'b0;
      chk1(flag, 1'b0);
      // duty value from low byte and duty bits
      v = 16'($urandom);
      wr(ADDR_PAIR_LO, v[7:0]);
      wr(ADDR_CTRL, {2'b00, v[9:8], 4'hC});
      cyc(2);
      chk({6'h00, duty}, {6'h00, v[7:0], v[9:8]});
      wr(ADDR_CTRL, CTRL_RST);
      cyc(2);
      chk({6'h00, duty}, 16'h0000);
      $display("duty test done");
      give_verdict();
   end
endmodule
